// File: hw/mhbp_defs.svh
// Purpose: Named constants for the module host byte port.
// Assumes: Included by bare name from the package and the design modules.
// Notes: Widths, counts, reset values and direction codes only; no logic here.
`ifndef MHBP_DEFS_SVH
`define MHBP_DEFS_SVH
`define MHBP_DATA_W 8
`define MHBP_ADDR_W 8
`define MHBP_NUM_REGS 256
`define MHBP_SYNC_W 4
// Synchroniser reset vector: flag 0, direction 0, select high, strobe high.
`define MHBP_SYNC_IDLE 4'h3
`define MHBP_BYTE_ZERO 8'h00
`define MHBP_DIR_READ 1'b1
`define MHBP_DIR_WRITE 1'b0
`endif

// File: hw/mhbp_pkg.sv
// Purpose: Types shared by the host byte port files.
// Assumes: mhbp_defs.svh gives the widths.
// Notes: Carrier structs group the user-side signals.
`include "mhbp_defs.svh"
package mhbp_pkg;
	typedef logic [`MHBP_DATA_W-1:0] mhbp_byte_t;
	typedef enum logic [1:0] {MHBP_IDLE, MHBP_WR_ACK, MHBP_RD_DRIVE, MHBP_RD_ACK} mhbp_state_e;
	typedef struct packed {
		logic wr_stb;
		logic [`MHBP_ADDR_W-1:0] addr;
		logic [`MHBP_DATA_W-1:0] data;
	} mhbp_wr_s;
	typedef struct packed {
		logic rd_stb;
		logic [`MHBP_ADDR_W-1:0] addr;
	} mhbp_rd_s;
endpackage

// File: hw/mhbp_port.sv
// Purpose: Device end of the byte port to the carrier's host serial bus device.
// Assumes: All port pins are asynchronous to SYS_CLK_IN and pass two flip-flops.
// Notes: Byte store is 256 locations; user logic sees writes and may also write.
// Notes on behaviour
// - Address strobe rising edge captures 8-bit address.
// - Direction high is read, low is write.
// - Write: ack low after byte latched.
// - Read: ack low after data driven.
// - Data path is 8-bit two-way bus.
// - Device may request carrier reset.
// - Unused carrier reset request stays high.
// - Boot override low keeps carrier running.
`timescale 1ns/10ps
`include "mhbp_defs.svh"
module mhbp_port (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// Host byte port pins
	input wire logic [`MHBP_DATA_W-1:0] DATA_IN,
	output logic [`MHBP_DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_OUT,
	input wire logic ADDR_STROBE_IN,
	input wire logic ACCESS_SELECT_N_IN,
	input wire logic XFER_DIR_IN,
	output logic ACK_N_OUT,
	// Carrier control lines
	input wire logic FLAG_FUNC_SELECT_IN,
	output logic CARRIER_RESET_REQ_N_OUT,
	output logic BOOT_OVERRIDE_N_OUT,
	output logic FLAG_FUNC_SELECT_OUT,
	// User side
	input wire logic USER_RESET_REQ_IN,
	input wire logic USER_BOOT_OVERRIDE_IN,
	input wire logic USER_WR_EN_IN,
	input wire logic [`MHBP_ADDR_W-1:0] USER_WR_ADDR_IN,
	input wire logic [`MHBP_DATA_W-1:0] USER_WR_DATA_IN,
	output mhbp_pkg::mhbp_wr_s HOST_WR_OUT,
	output mhbp_pkg::mhbp_rd_s HOST_RD_OUT
);
	// Two-stage synchronisers for the control pins: strobe, select, direction, flag select.
	logic [`MHBP_SYNC_W-1:0] sync1_reg;
	logic [`MHBP_SYNC_W-1:0] sync2_reg;
	logic [`MHBP_DATA_W-1:0] dsync1_reg;
	logic [`MHBP_DATA_W-1:0] dsync2_reg;
	logic strobe_prev_reg;
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			// Strobe starts high so a pin already high at release is no edge.
			sync1_reg <= `MHBP_SYNC_IDLE;
			sync2_reg <= `MHBP_SYNC_IDLE;
			dsync1_reg <= `MHBP_BYTE_ZERO;
			dsync2_reg <= `MHBP_BYTE_ZERO;
			strobe_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {FLAG_FUNC_SELECT_IN, XFER_DIR_IN, ACCESS_SELECT_N_IN, ADDR_STROBE_IN};
			sync2_reg <= sync1_reg;
			dsync1_reg <= DATA_IN;
			dsync2_reg <= dsync1_reg;
			strobe_prev_reg <= sync2_reg[0];
		end
	end
	logic strobe_s;
	logic sel_n_s;
	logic dir_s;
	logic flag_s;
	logic strobe_rise;
	assign strobe_s = sync2_reg[0];
	assign sel_n_s = sync2_reg[1];
	assign dir_s = sync2_reg[2];
	assign flag_s = sync2_reg[3];
	assign strobe_rise = strobe_s && !strobe_prev_reg;

	// Access state machine and address register.
	mhbp_pkg::mhbp_state_e state_reg, state_next;
	logic [`MHBP_ADDR_W-1:0] addr_reg, addr_next;
	logic [`MHBP_DATA_W-1:0] dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic ack_n_reg, ack_n_next;
	mhbp_pkg::mhbp_wr_s wr_reg, wr_next;
	mhbp_pkg::mhbp_rd_s rd_reg, rd_next;
	logic [`MHBP_DATA_W-1:0] mem_rd_data;
	logic mem_wr_en;
	logic [`MHBP_ADDR_W-1:0] mem_wr_addr;
	logic [`MHBP_DATA_W-1:0] mem_wr_data;

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		dout_next = dout_reg;
		oe_next = oe_reg;
		ack_n_next = ack_n_reg;
		wr_next = '0;
		rd_next = '0;
		// An address strobe is only honoured outside a data phase.
		if (strobe_rise && state_reg == mhbp_pkg::MHBP_IDLE) begin
			addr_next = dsync2_reg;
		end
		case (state_reg)
			mhbp_pkg::MHBP_IDLE: begin
				oe_next = 1'b0;
				ack_n_next = 1'b1;
				if (!sel_n_s && !strobe_rise) begin
					if (dir_s == `MHBP_DIR_WRITE) begin
						wr_next.wr_stb = 1'b1;
						wr_next.addr = addr_reg;
						wr_next.data = dsync2_reg;
						ack_n_next = 1'b0;
						state_next = mhbp_pkg::MHBP_WR_ACK;
					end else begin
						rd_next.rd_stb = 1'b1;
						rd_next.addr = addr_reg;
						state_next = mhbp_pkg::MHBP_RD_DRIVE;
					end
				end
			end
			mhbp_pkg::MHBP_WR_ACK: begin
				if (sel_n_s) begin
					ack_n_next = 1'b1;
					state_next = mhbp_pkg::MHBP_IDLE;
				end
			end
			mhbp_pkg::MHBP_RD_DRIVE: begin
				// Store output is registered, so data is ready one cycle after the strobe.
				dout_next = mem_rd_data;
				oe_next = 1'b1;
				state_next = mhbp_pkg::MHBP_RD_ACK;
				if (sel_n_s) begin
					oe_next = 1'b0;
					state_next = mhbp_pkg::MHBP_IDLE;
				end
			end
			mhbp_pkg::MHBP_RD_ACK: begin
				ack_n_next = 1'b0;
				if (sel_n_s) begin
					ack_n_next = 1'b1;
					oe_next = 1'b0;
					state_next = mhbp_pkg::MHBP_IDLE;
				end
			end
			default: begin
				state_next = mhbp_pkg::MHBP_IDLE;
				oe_next = 1'b0;
				ack_n_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= mhbp_pkg::MHBP_IDLE;
			addr_reg <= `MHBP_BYTE_ZERO;
			dout_reg <= `MHBP_BYTE_ZERO;
			oe_reg <= 1'b0;
			ack_n_reg <= 1'b1;
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
			ack_n_reg <= ack_n_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// Host writes take priority over user writes to the store.
	assign mem_wr_en = wr_next.wr_stb || USER_WR_EN_IN;
	assign mem_wr_addr = wr_next.wr_stb ? wr_next.addr : USER_WR_ADDR_IN;
	assign mem_wr_data = wr_next.wr_stb ? wr_next.data : USER_WR_DATA_IN;

	mhbp_regmem mhbp_regmem_inst (
		.clk(SYS_CLK_IN),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_addr(addr_reg),
		.rd_data(mem_rd_data)
	);

	// Carrier control lines, registered; reset request is inactive high by default.
	logic creset_n_reg, creset_n_next;
	logic boot_n_reg, boot_n_next;
	logic flag_reg, flag_next;
	always_comb begin
		creset_n_next = !USER_RESET_REQ_IN;
		boot_n_next = !USER_BOOT_OVERRIDE_IN;
		flag_next = flag_s;
	end
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			creset_n_reg <= 1'b1;
			boot_n_reg <= 1'b1;
			flag_reg <= 1'b0;
		end else begin
			creset_n_reg <= creset_n_next;
			boot_n_reg <= boot_n_next;
			flag_reg <= flag_next;
		end
	end

	assign DATA_OUT = dout_reg;
	assign DATA_OE_OUT = oe_reg;
	assign ACK_N_OUT = ack_n_reg;
	assign CARRIER_RESET_REQ_N_OUT = creset_n_reg;
	assign BOOT_OVERRIDE_N_OUT = boot_n_reg;
	assign FLAG_FUNC_SELECT_OUT = flag_reg;
	assign HOST_WR_OUT = wr_reg;
	assign HOST_RD_OUT = rd_reg;

	a_addr_capture: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(strobe_rise && state_reg == mhbp_pkg::MHBP_IDLE) |=> addr_reg == $past(dsync2_reg))
		else $error("address not captured on strobe");
	a_write_ack: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		HOST_WR_OUT.wr_stb |-> !ACK_N_OUT && !DATA_OE_OUT)
		else $error("write not acknowledged");
	a_read_ack: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		$fell(ACK_N_OUT) && state_reg == mhbp_pkg::MHBP_RD_ACK |-> DATA_OE_OUT)
		else $error("read ack without data driven");
	a_dir_decode: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(state_reg == mhbp_pkg::MHBP_IDLE && !sel_n_s && !strobe_rise) |=>
		(HOST_WR_OUT.wr_stb == ($past(dir_s) == `MHBP_DIR_WRITE)))
		else $error("direction decoded wrongly");
	a_release_end: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		(sel_n_s && state_reg != mhbp_pkg::MHBP_IDLE) |=> ##[0:1] (ACK_N_OUT && !DATA_OE_OUT))
		else $error("ack or data not released");
	a_oe_only_read: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		DATA_OE_OUT |-> state_reg inside {mhbp_pkg::MHBP_RD_ACK, mhbp_pkg::MHBP_RD_DRIVE})
		else $error("data driven outside read");
	a_read_data: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		$rose(DATA_OE_OUT) |-> DATA_OUT == $past(mem_rd_data))
		else $error("read data not from store");
	a_reset_req: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!USER_RESET_REQ_IN ##1 !USER_RESET_REQ_IN |-> CARRIER_RESET_REQ_N_OUT)
		else $error("carrier reset without request");
	a_boot_ovr: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		USER_BOOT_OVERRIDE_IN |=> !BOOT_OVERRIDE_N_OUT)
		else $error("boot override not driven");
	a_flag_follow: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		1'b1 |=> FLAG_FUNC_SELECT_OUT == $past(flag_s))
		else $error("flag select not followed");
	a_reset_drive: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		USER_RESET_REQ_IN |=> !CARRIER_RESET_REQ_N_OUT)
		else $error("reset request not driven");
	c_write: cover property (@(posedge SYS_CLK_IN) HOST_WR_OUT.wr_stb);
	c_read: cover property (@(posedge SYS_CLK_IN) $fell(ACK_N_OUT) && DATA_OE_OUT);
	c_addr: cover property (@(posedge SYS_CLK_IN) strobe_rise);
endmodule

// File: hw/mhbp_regmem.sv
// Purpose: Byte store behind the host byte port, with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data appears one cycle after the read address.
`timescale 1ns/10ps
`include "mhbp_defs.svh"
module mhbp_regmem (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [`MHBP_ADDR_W-1:0] wr_addr,
	input wire logic [`MHBP_DATA_W-1:0] wr_data,
	input wire logic [`MHBP_ADDR_W-1:0] rd_addr,
	output logic [`MHBP_DATA_W-1:0] rd_data
);
	logic [`MHBP_DATA_W-1:0] mem [0:`MHBP_NUM_REGS-1];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// File: testbench/mhbp_host_model.sv
// Purpose: Carrier host bus device that drives the byte port pins.
// Assumes: Strobe, select, direction and driven bytes change at the falling edge; a released bus changes at the rising edge.
// Notes: A released bus shows a shifting pattern from 8'h5A, with the inverted top bit fed back, instead of holding the last byte.
`timescale 1ns/10ps
module mhbp_host_model (
	input wire logic clk,
	input wire logic ack_n,
	input wire logic dev_oe,
	input wire mhbp_pkg::mhbp_byte_t dev_data,
	output logic strobe,
	output logic sel_n,
	output logic dir,
	output mhbp_pkg::mhbp_byte_t bus
);
	logic host_oe;
	mhbp_pkg::mhbp_byte_t host_data;
	mhbp_pkg::mhbp_byte_t noise;
	initial begin
		strobe = 1'b0;
		sel_n = 1'b1;
		dir = 1'b0;
		host_oe = 1'b0;
		host_data = 8'h00;
		noise = 8'h5A;
	end
	always @(posedge clk) noise <= {noise[6:0], ~noise[7]};
	assign bus = dev_oe ? dev_data : (host_oe ? host_data : noise);
	task put_addr(input mhbp_pkg::mhbp_byte_t a);
		@(negedge clk);
		host_oe = 1'b1;
		host_data = a;
		repeat (3) @(negedge clk);
		strobe = 1'b1;
		repeat (4) @(negedge clk);
		strobe = 1'b0;
		host_oe = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Select stays low until ack is seen or 20 clocks pass, so a device slower than that is cut short.
	task access(input logic rd, input mhbp_pkg::mhbp_byte_t wd,
		output mhbp_pkg::mhbp_byte_t q, output logic ok);
		int i;
		ok = 1'b0;
		q = 8'h00;
		@(negedge clk);
		dir = rd;
		host_oe = ~rd;
		host_data = wd;
		repeat (3) @(negedge clk);
		sel_n = 1'b0;
		for (i = 0; i < 20 && !ok; i++) begin
			@(posedge clk);
			ok = (ack_n === 1'b0);
		end
		q = bus;
		@(negedge clk);
		sel_n = 1'b1;
		for (i = 0; i < 20 && ack_n !== 1'b1; i++) @(negedge clk);
		ok = ok && (ack_n === 1'b1);
		host_oe = 1'b0;
		repeat (2) @(negedge clk);
	endtask
endmodule

// File: testbench/test_module_host_byte_port.sv
// Purpose: Self-checking bench for the module host byte port.
// Assumes: Host model owns the port pins; bench owns user and control inputs.
// Notes: Expected bytes come from the bench's own stimulus.
`timescale 1ns/10ps
module test_module_host_byte_port;
	logic clk, rst_n, stb, sel_n, dir, ack_n, oe, flag_in, rreq, boot, uwe, ok;
	logic crst_n, boot_n, flag_out;
	mhbp_pkg::mhbp_byte_t bus, dout, uwa, uwd, q;
	mhbp_pkg::mhbp_wr_s wr, last_wr;
	mhbp_pkg::mhbp_rd_s rd, last_rd;
	int errors, n_checks;
	mhbp_port mhbp_port_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .DATA_IN(bus),
		.DATA_OUT(dout), .DATA_OE_OUT(oe), .ADDR_STROBE_IN(stb), .ACCESS_SELECT_N_IN(sel_n),
		.XFER_DIR_IN(dir), .ACK_N_OUT(ack_n), .FLAG_FUNC_SELECT_IN(flag_in),
		.CARRIER_RESET_REQ_N_OUT(crst_n), .BOOT_OVERRIDE_N_OUT(boot_n),
		.FLAG_FUNC_SELECT_OUT(flag_out), .USER_RESET_REQ_IN(rreq),
		.USER_BOOT_OVERRIDE_IN(boot), .USER_WR_EN_IN(uwe), .USER_WR_ADDR_IN(uwa),
		.USER_WR_DATA_IN(uwd), .HOST_WR_OUT(wr), .HOST_RD_OUT(rd));
	mhbp_host_model mhbp_host_model_inst (.clk(clk), .ack_n(ack_n), .dev_oe(oe),
		.dev_data(dout), .strobe(stb), .sel_n(sel_n), .dir(dir), .bus(bus));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wr.wr_stb) last_wr <= wr;
		if (rd.rd_stb) last_rd <= rd;
	end
	task check(input mhbp_pkg::mhbp_byte_t seen, input mhbp_pkg::mhbp_byte_t exp,
		input string msg);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Boundary addresses 00 and FF plus a middle one, each written then read back.
	task test_host_access;
		mhbp_pkg::mhbp_byte_t a[3];
		a = '{8'h00, 8'hFF, 8'h3C};
		foreach (a[i]) begin
			mhbp_host_model_inst.put_addr(a[i]);
			mhbp_host_model_inst.access(1'b0, ~a[i] ^ 8'h5A, q, ok);
			check({7'h00, ok}, 8'h01, "write ack");
			check(last_wr.addr, a[i], "write addr");
			check(last_wr.data, ~a[i] ^ 8'h5A, "write data");
			check({7'h00, oe}, 8'h00, "bus driven after write");
			mhbp_host_model_inst.access(1'b1, 8'h00, q, ok);
			check({7'h00, ok}, 8'h01, "read ack and release");
			check(q, ~a[i] ^ 8'h5A, "read data");
			check(last_rd.addr, a[i], "read addr");
			check({7'h00, oe}, 8'h00, "bus held after read");
		end
		$display("test_host_access done");
	endtask
	task test_user_write;
		@(negedge clk);
		uwe = 1'b1;
		uwa = 8'h81;
		uwd = 8'hC3;
		@(negedge clk);
		uwe = 1'b0;
		mhbp_host_model_inst.put_addr(8'h81);
		mhbp_host_model_inst.access(1'b1, 8'h00, q, ok);
		check(q, 8'hC3, "user byte readback");
		$display("test_user_write done");
	endtask
	task test_control;
		check({7'h00, crst_n}, 8'h01, "carrier reset idle");
		@(negedge clk);
		rreq = 1'b1;
		boot = 1'b1;
		flag_in = 1'b1;
		repeat (4) @(negedge clk);
		check({7'h00, crst_n}, 8'h00, "carrier reset request");
		check({7'h00, boot_n}, 8'h00, "boot override");
		check({7'h00, flag_out}, 8'h01, "flag select");
		rreq = 1'b0;
		boot = 1'b0;
		flag_in = 1'b0;
		repeat (4) @(negedge clk);
		check({5'h00, crst_n, boot_n, flag_out}, 8'h06, "control release");
		$display("test_control done");
	endtask
	initial begin
		errors = 0;
		n_checks = 0;
		rst_n = 1'b0;
		flag_in = 1'b0;
		rreq = 1'b0;
		boot = 1'b0;
		uwe = 1'b0;
		uwa = 8'h00;
		uwd = 8'h00;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		test_host_access;
		test_user_write;
		test_control;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
endmodule
